// ---- logic/tmc_mode_ctrl.sv ----
/*
  Transmitter mode controller: chooses operate or standby from panel,
  serial (register) and remote terminal inputs, applies mute, drives the
  supply stage, indicators and open-collector remote outputs.
  Assumes a classic Wishbone master on clk_i and that pins are asynchronous.
*/
// Functional notes
// - Operate enables supply, operate lamp, driver enable
// - Standby disables them; supply-good indication unaffected
// - Mute keeps supply on, suppresses RF output
// - Upconverter unlocked or absent forces mute
// - Operate from remote pin, panel, serial
// - Refuse operate: overtemp, mute, amplifier absent
// - Standby from remote pin, panel, serial
// - Open output-path loop forces mute
// - No operate with fault or remote standby; a fault only blocks entry to operate, it does not end operate
// - Remote state pulled low in operate
// - Fault chain pulled low when unfaulted
// - Aux lines: digital in, open-drain out, analog
module tmc_mode_ctrl #(
  parameter int DEBOUNCE_CYC = tmc_pkg::DEB_CYC
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             irq_o,
  input  wire logic        panel_operate_select_i,
  input  wire logic        panel_standby_key_i,
  input  wire logic        remote_go_live_in_n_i,
  input  wire logic        remote_idle_in_n_i,
  input  wire logic        heatsink_over_temp_i,
  input  wire logic        amp_interlock_i,
  input  wire logic        upconv_unlocked_i,
  input  wire logic        upconv_absent_i,
  input  wire logic        output_path_loop_open_i,
  input  wire logic        supply_ok_i,
  output logic             supply_28v_en_o,
  output logic             operate_led_o,
  output logic             driver_enable_o,
  output logic             supply_good_indicator_o,
  output logic             rf_enable_o,
  output logic             mute_o,
  output logic             remote_state_out_o,
  output logic             remote_state_out_oe_o,
  output logic             remote_fault_chain_out_o,
  output logic             remote_fault_chain_out_oe_o,
  input  wire logic        remote_aux_line_1_i,
  output logic             remote_aux_line_1_o,
  output logic             remote_aux_line_1_oe_o,
  input  wire logic        remote_aux_line_2_i,
  output logic             remote_aux_line_2_o,
  output logic             remote_aux_line_2_oe_o,
  output logic      [1:0]  aux_analog_sel_o
);

  // Line drives low only when configured as output and asked to go low
  function automatic logic aux_drives(input logic [1:0] mode, input logic lvl);
    return (mode == tmc_pkg::AUX_DOUT) && !lvl;
  endfunction : aux_drives

  logic [tmc_pkg::SY_W-1:0]    sync1_r;
  logic [tmc_pkg::SY_W-1:0]    sync2_r;
  logic [1:0]                  rem_db_r;     // Debounced, active low
  logic [tmc_pkg::DEB_W-1:0]   deb_cnt_r [2];
  tmc_pkg::tmc_mode_t          mode_r;
  tmc_pkg::tmc_mode_t          mode_nxt;
  logic                        mute_r;
  logic                        fault_r;
  logic                        ack_r;
  logic [31:0]                 dat_r;
  logic                        cmd_op_r;
  logic                        cmd_sb_r;
  logic [tmc_pkg::INT_W-1:0]   int_stat_r;
  logic [tmc_pkg::INT_W-1:0]   int_mask_r;
  logic [5:0]                  aux_cfg_r;
  logic                        irq_r;
  logic                        supply_r;
  logic                        led_r;
  logic                        drv_r;
  logic                        good_r;
  logic                        rf_r;
  logic                        state_oe_r;
  logic                        chain_oe_r;
  logic                        aux1_oe_r;
  logic                        aux2_oe_r;
  logic [1:0]                  ana_r;
  logic                        mute_cause;
  logic                        fault_now;
  logic                        op_req;
  logic                        sb_req;
  logic                        op_block;
  logic                        wr_hit;
  logic [tmc_pkg::INT_W-1:0]   int_evt;
  logic [31:0]                 rd_mux;
  logic [31:0]                 status_w;

  // Two-stage synchroniser for every pin except the two panel keys; only the second stage is used
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      // Remote command pins idle high; clearing them low would fake a command
      sync1_r <= tmc_pkg::SY_W'(1 << tmc_pkg::SY_GO_N | 1 << tmc_pkg::SY_IDLE_N);
      sync2_r <= tmc_pkg::SY_W'(1 << tmc_pkg::SY_GO_N | 1 << tmc_pkg::SY_IDLE_N);
    end else begin
      sync1_r <= {remote_aux_line_2_i, remote_aux_line_1_i, supply_ok_i,
                  output_path_loop_open_i, upconv_absent_i, upconv_unlocked_i,
                  amp_interlock_i, heatsink_over_temp_i, remote_idle_in_n_i,
                  remote_go_live_in_n_i};
      sync2_r <= sync1_r;
    end
  end

  // Debounce the remote command pins: a new level must hold the full time
  // so contact bounce on long terminal wiring cannot toggle the mode
  for (genvar g = 0; g < 2; g++) begin : g_deb
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        rem_db_r[g]  <= 1'b1;
        deb_cnt_r[g] <= '0;
      end else if (sync2_r[tmc_pkg::SY_GO_N + g] == rem_db_r[g]) begin
        deb_cnt_r[g] <= '0;
      end else if (deb_cnt_r[g] == tmc_pkg::DEB_W'(DEBOUNCE_CYC - 1)) begin
        rem_db_r[g]  <= sync2_r[tmc_pkg::SY_GO_N + g];
        deb_cnt_r[g] <= '0;
      end else begin
        deb_cnt_r[g] <= deb_cnt_r[g] + 1'b1;
      end
    end
  end

  // Request and condition decode
  assign mute_cause = sync2_r[tmc_pkg::SY_UNLOCK] | sync2_r[tmc_pkg::SY_UPC_ABS]
                    | sync2_r[tmc_pkg::SY_LOOP];
  assign fault_now  = sync2_r[tmc_pkg::SY_OVER_T] | sync2_r[tmc_pkg::SY_AMP_ABS]
                    | mute_cause;
  assign op_req = !rem_db_r[0] | panel_operate_select_i | cmd_op_r;
  assign sb_req = !rem_db_r[1] | panel_standby_key_i | cmd_sb_r;
  assign op_block = fault_now;

  // Mode choice; standby wins over a simultaneous operate request
  always_comb begin
    mode_nxt = mode_r;
    if (sb_req) begin
      mode_nxt = tmc_pkg::MODE_STANDBY;
    end else if (op_req && !op_block) begin
      mode_nxt = tmc_pkg::MODE_OPERATE;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_r <= tmc_pkg::MODE_STANDBY;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  // Mute exists only inside operate; fault feeds the interlock chain
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mute_r  <= 1'b0;
      fault_r <= 1'b0;
    end else begin
      mute_r  <= (mode_r == tmc_pkg::MODE_OPERATE) && mute_cause;
      fault_r <= fault_now;
    end
  end

  // Supply, indicators and open-collector drives, all registered
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      supply_r   <= 1'b0;
      led_r      <= 1'b0;
      drv_r      <= 1'b0;
      good_r     <= 1'b0;
      rf_r       <= 1'b0;
      state_oe_r <= 1'b0;
      chain_oe_r <= 1'b0;
    end else begin
      supply_r   <= mode_r == tmc_pkg::MODE_OPERATE;
      led_r      <= mode_r == tmc_pkg::MODE_OPERATE;
      drv_r      <= mode_r == tmc_pkg::MODE_OPERATE;
      good_r     <= sync2_r[tmc_pkg::SY_SUPPLY];
      rf_r       <= (mode_r == tmc_pkg::MODE_OPERATE) && !mute_cause;
      state_oe_r <= mode_r == tmc_pkg::MODE_OPERATE;
      chain_oe_r <= !fault_now;
    end
  end

  // Auxiliary lines; analog mode releases the pin and selects the ADC path
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      aux1_oe_r <= 1'b0;
      aux2_oe_r <= 1'b0;
      ana_r     <= 2'h0;
    end else begin
      aux1_oe_r <= aux_drives(aux_cfg_r[1:0], aux_cfg_r[tmc_pkg::AUX_LVL_LSB]);
      aux2_oe_r <= aux_drives(aux_cfg_r[3:2], aux_cfg_r[tmc_pkg::AUX_LVL_LSB+1]);
      ana_r     <= {aux_cfg_r[3:2] == tmc_pkg::AUX_AIN, aux_cfg_r[1:0] == tmc_pkg::AUX_AIN};
    end
  end

  // Wishbone slave: one wait state, ack drops the cycle after it was given
  assign wr_hit = wb_cyc_i && wb_stb_i && wb_we_i && ack_r && wb_sel_i[0];
  assign status_w = {21'h000000, !rem_db_r[1], !rem_db_r[0],
                     sync2_r[tmc_pkg::SY_UPC_ABS], sync2_r[tmc_pkg::SY_UNLOCK],
                     sync2_r[tmc_pkg::SY_LOOP], sync2_r[tmc_pkg::SY_AMP_ABS],
                     sync2_r[tmc_pkg::SY_OVER_T], rf_r, fault_r, mute_r,
                     mode_r == tmc_pkg::MODE_OPERATE};

  always_comb begin
    unique case (wb_adr_i)
      tmc_pkg::REG_STATUS:   rd_mux = status_w;
      tmc_pkg::REG_INT_STAT: rd_mux = {27'h0000000, int_stat_r};
      tmc_pkg::REG_INT_MASK: rd_mux = {27'h0000000, int_mask_r};
      tmc_pkg::REG_AUX_CFG:  rd_mux = {26'h0000000, aux_cfg_r};
      tmc_pkg::REG_AUX_IN:   rd_mux = {30'h00000000, sync2_r[tmc_pkg::SY_AUX2],
                                       sync2_r[tmc_pkg::SY_AUX1]};
      default:               rd_mux = 32'h00000000; // Control and unmapped read zero
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      dat_r <= 32'h00000000;
    end else begin
      ack_r <= wb_cyc_i && wb_stb_i && !ack_r;
      dat_r <= rd_mux;
    end
  end

  // Serial commands arrive as one-cycle pulses written to control
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmd_op_r <= 1'b0;
      cmd_sb_r <= 1'b0;
    end else begin
      cmd_op_r <= wr_hit && wb_adr_i == tmc_pkg::REG_CTRL && wb_dat_i[tmc_pkg::CTRL_OPERATE];
      cmd_sb_r <= wr_hit && wb_adr_i == tmc_pkg::REG_CTRL && wb_dat_i[tmc_pkg::CTRL_STANDBY];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      int_mask_r <= tmc_pkg::INT_MASK_RST;
      aux_cfg_r  <= tmc_pkg::AUX_CFG_RST;
    end else if (wr_hit && wb_adr_i == tmc_pkg::REG_INT_MASK) begin
      int_mask_r <= wb_dat_i[tmc_pkg::INT_W-1:0];
    end else if (wr_hit && wb_adr_i == tmc_pkg::REG_AUX_CFG) begin
      aux_cfg_r  <= wb_dat_i[5:0];
    end
  end

  // Sticky events, write one to clear; a new event beats the clear
  assign int_evt[tmc_pkg::INT_OPERATE] = mode_r == tmc_pkg::MODE_STANDBY
                                       && mode_nxt == tmc_pkg::MODE_OPERATE;
  assign int_evt[tmc_pkg::INT_STANDBY] = mode_r == tmc_pkg::MODE_OPERATE
                                       && mode_nxt == tmc_pkg::MODE_STANDBY;
  assign int_evt[tmc_pkg::INT_MUTE]    = (mode_r == tmc_pkg::MODE_OPERATE)
                                       && mute_cause && !mute_r;
  assign int_evt[tmc_pkg::INT_FAULT]   = fault_now && !fault_r;
  assign int_evt[tmc_pkg::INT_REFUSED] = op_req && op_block && !sb_req
                                       && mode_r == tmc_pkg::MODE_STANDBY;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      int_stat_r <= '0;
    end else if (wr_hit && wb_adr_i == tmc_pkg::REG_INT_STAT) begin
      int_stat_r <= (int_stat_r & ~wb_dat_i[tmc_pkg::INT_W-1:0]) | int_evt;
    end else begin
      int_stat_r <= int_stat_r | int_evt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(int_stat_r & int_mask_r);
    end
  end

  // Port drive; open-collector data pins only ever pull low
  assign wb_ack_o                 = ack_r;
  assign wb_dat_o                 = dat_r;
  assign irq_o                    = irq_r;
  assign supply_28v_en_o          = supply_r;
  assign operate_led_o            = led_r;
  assign driver_enable_o          = drv_r;
  assign supply_good_indicator_o  = good_r;
  assign rf_enable_o              = rf_r;
  assign mute_o                   = mute_r;
  assign remote_state_out_o       = 1'b0;
  assign remote_state_out_oe_o    = state_oe_r;
  assign remote_fault_chain_out_o = 1'b0;
  assign remote_fault_chain_out_oe_o = chain_oe_r;
  assign remote_aux_line_1_o      = 1'b0;
  assign remote_aux_line_1_oe_o   = aux1_oe_r;
  assign remote_aux_line_2_o      = 1'b0;
  assign remote_aux_line_2_oe_o   = aux2_oe_r;
  assign aux_analog_sel_o         = ana_r;

  // Checks
  sequence s_in_operate;
    mode_r == tmc_pkg::MODE_OPERATE;
  endsequence
  sequence s_in_standby;
    mode_r == tmc_pkg::MODE_STANDBY;
  endsequence

  a_operate_outputs: assert property (@(posedge clk_i) disable iff (rst_i)
    s_in_operate |=> supply_28v_en_o && operate_led_o && driver_enable_o)
    else $error("operate outputs not asserted");

  a_standby_outputs: assert property (@(posedge clk_i) disable iff (rst_i)
    s_in_standby |=> !supply_28v_en_o && !operate_led_o && !driver_enable_o
                     && supply_good_indicator_o == $past(sync2_r[tmc_pkg::SY_SUPPLY]))
    else $error("standby outputs wrong");

  a_rf_needs_supply: assert property (@(posedge clk_i) disable iff (rst_i)
    rf_enable_o |-> supply_28v_en_o && !mute_o)
    else $error("rf enabled without supply or while muted");

  a_upconv_mute: assert property (@(posedge clk_i) disable iff (rst_i)
    s_in_operate ##0 (sync2_r[tmc_pkg::SY_UNLOCK] || sync2_r[tmc_pkg::SY_UPC_ABS]) && !sb_req
      |=> mute_o && !rf_enable_o ##1 supply_28v_en_o)
    else $error("upconverter fault did not mute");

  a_operate_accept: assert property (@(posedge clk_i) disable iff (rst_i)
    s_in_standby ##0 (panel_operate_select_i || cmd_op_r) && !sb_req && !fault_now
      |=> s_in_operate)
    else $error("operate request not accepted");

  a_operate_refused: assert property (@(posedge clk_i) disable iff (rst_i)
    s_in_standby ##0 (sync2_r[tmc_pkg::SY_OVER_T] || sync2_r[tmc_pkg::SY_AMP_ABS]
                      || mute_cause) |=> s_in_standby)
    else $error("operate entered while blocked");

  a_standby_accept: assert property (@(posedge clk_i) disable iff (rst_i)
    (panel_standby_key_i || cmd_sb_r) |=> s_in_standby)
    else $error("standby request not accepted");

  a_loop_mute: assert property (@(posedge clk_i) disable iff (rst_i)
    s_in_operate ##0 sync2_r[tmc_pkg::SY_LOOP] |=> mute_o)
    else $error("open loop did not mute");

  a_remote_idle_holds: assert property (@(posedge clk_i) disable iff (rst_i)
    !rem_db_r[1] |=> s_in_standby)
    else $error("operate while remote standby active");

  a_state_pin: assert property (@(posedge clk_i) disable iff (rst_i)
    remote_state_out_oe_o == $past(mode_r == tmc_pkg::MODE_OPERATE))
    else $error("remote state pin wrong");

  a_fault_chain: assert property (@(posedge clk_i) disable iff (rst_i)
    fault_now |=> !remote_fault_chain_out_oe_o)
    else $error("fault chain still closed under fault");

  a_aux_drive: assert property (@(posedge clk_i) disable iff (rst_i)
    aux_cfg_r[1:0] != tmc_pkg::AUX_DOUT |=> !remote_aux_line_1_oe_o)
    else $error("aux line driven outside output mode");

  a_debounce_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    $changed(rem_db_r[0]) |-> $past(deb_cnt_r[0]) == tmc_pkg::DEB_W'(DEBOUNCE_CYC - 1))
    else $error("remote input changed before debounce time");

endmodule : tmc_mode_ctrl

// ---- logic/tmc_pkg.sv ----
/*
  Constants for the transmitter mode controller: register map, field
  positions, reset values, state codes, input bit order and timing.
  Assumes a single 10 MHz system clock.
*/
package tmc_pkg;
  // Register byte addresses
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_STATUS   = 8'h04;
  localparam logic [7:0] REG_INT_STAT = 8'h08;
  localparam logic [7:0] REG_INT_MASK = 8'h0c;
  localparam logic [7:0] REG_AUX_CFG  = 8'h10;
  localparam logic [7:0] REG_AUX_IN   = 8'h14;

  // Control register: command pulses from the serial interface handler
  localparam int CTRL_OPERATE = 0;
  localparam int CTRL_STANDBY = 1;

  // Status register fields
  localparam int ST_OPERATE    = 0;
  localparam int ST_MUTE       = 1;
  localparam int ST_FAULT      = 2;
  localparam int ST_RF_ON      = 3;
  localparam int ST_OVER_TEMP  = 4;
  localparam int ST_AMP_ABSENT = 5;
  localparam int ST_LOOP_OPEN  = 6;
  localparam int ST_UNLOCKED   = 7;
  localparam int ST_UPC_ABSENT = 8;
  localparam int ST_REM_GO     = 9;
  localparam int ST_REM_IDLE   = 10;

  // Interrupt status and mask fields
  localparam int INT_W        = 5;
  localparam int INT_OPERATE  = 0;
  localparam int INT_STANDBY  = 1;
  localparam int INT_MUTE     = 2;
  localparam int INT_FAULT    = 3;
  localparam int INT_REFUSED  = 4;
  localparam logic [INT_W-1:0] INT_MASK_RST = 5'h00;

  // Auxiliary line configuration: two bits of mode per line, one drive bit
  localparam int AUX_MODE_W   = 2;
  localparam int AUX_LVL_LSB  = 4;
  localparam logic [1:0] AUX_DIN  = 2'h0;
  localparam logic [1:0] AUX_DOUT = 2'h1;
  localparam logic [1:0] AUX_AIN  = 2'h2;
  localparam logic [5:0] AUX_CFG_RST = 6'h30;

  // Order of the bits in the pin synchroniser
  localparam int SY_GO_N     = 0;
  localparam int SY_IDLE_N   = 1;
  localparam int SY_OVER_T   = 2;
  localparam int SY_AMP_ABS  = 3;
  localparam int SY_UNLOCK   = 4;
  localparam int SY_UPC_ABS  = 5;
  localparam int SY_LOOP     = 6;
  localparam int SY_SUPPLY   = 7;
  localparam int SY_AUX1     = 8;
  localparam int SY_AUX2     = 9;
  localparam int SY_W        = 10;

  // Remote input debounce time
  localparam int CLK_KHZ      = 10000;
  localparam int DEB_TIME_US  = 1000;
  localparam int DEB_CYC      = (DEB_TIME_US * CLK_KHZ + 999) / 1000;
  localparam int DEB_W        = 14;

  typedef enum logic [1:0] {
    MODE_STANDBY = 2'b01,
    MODE_OPERATE = 2'b10
  } tmc_mode_t;
endpackage : tmc_pkg

// ---- tb/tmc_far_side.sv ----
/*
  Far-side model: remote control contacts and pull-ups on the terminal block.
  Assumes open-collector lines, so a released line reads high.
*/
module tmc_far_side (
  input  wire logic clk_i,
  input  wire logic slow_i,
  input  wire logic go_req_i,
  input  wire logic idle_req_i,
  input  wire logic loop_closed_i,
  input  wire logic aux_pull_low_i,
  input  wire logic state_o_i,
  input  wire logic state_oe_i,
  input  wire logic chain_o_i,
  input  wire logic chain_oe_i,
  input  wire logic aux1_o_i,
  input  wire logic aux1_oe_i,
  output logic      go_n_o,
  output logic      idle_n_o,
  output logic      loop_open_o,
  output logic      state_line_o,
  output logic      chain_line_o,
  output logic      aux1_line_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] go_d_r;
  logic [3:0] idle_d_r;

  // Slow station: contacts close four cycles after being asked
  always_ff @(posedge clk_i) begin
    go_d_r   <= {go_d_r[2:0], go_req_i};
    idle_d_r <= {idle_d_r[2:0], idle_req_i};
  end

  // A closed contact pulls to ground; an open one leaves the pull-up
  assign go_n_o       = ~(slow_i ? go_d_r[3] : go_req_i);
  assign idle_n_o     = ~(slow_i ? idle_d_r[3] : idle_req_i);
  assign loop_open_o  = ~loop_closed_i;
  assign state_line_o = state_oe_i ? state_o_i : 1'b1;
  assign chain_line_o = chain_oe_i ? chain_o_i : 1'b1;
  assign aux1_line_o  = (aux1_oe_i ? aux1_o_i : 1'b1) & ~aux_pull_low_i;
endmodule : tmc_far_side

// ---- tb/test_tmc_mode_ctrl.sv ----
/*
  Self-checking bench for the transmitter mode controller.
  Assumes a 10 MHz clock and a short debounce of 4 cycles.
*/
module test_tmc_mode_ctrl;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_i, rst_i, cyc, stb, we, ack, irq, p_op, p_sb, hot, amp, unl, upa, s_ok;
  logic        slow, go, idle, loop_ok, auxlo, st_o, st_oe, ch_o, ch_oe, a1_o, a1_oe;
  logic        go_n, idle_n, lopen, st_l, ch_l, a1_l, a2_o, a2_oe;
  logic        sgi, sup, led, drv, rf, mute;
  logic [1:0]  asel;
  logic [7:0]  adr, ov;
  logic [31:0] wdat, rdat, q;
  int          bad_count, cmp_count;

  assign ov = {sgi, sup, led, drv, rf, mute, st_l, ch_l};

  tmc_mode_ctrl #(.DEBOUNCE_CYC(4)) uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .irq_o(irq), .panel_operate_select_i(p_op),
    .panel_standby_key_i(p_sb), .remote_go_live_in_n_i(go_n), .remote_idle_in_n_i(idle_n),
    .heatsink_over_temp_i(hot), .amp_interlock_i(amp), .upconv_unlocked_i(unl),
    .upconv_absent_i(upa), .output_path_loop_open_i(lopen), .supply_ok_i(s_ok),
    .supply_28v_en_o(sup), .operate_led_o(led), .driver_enable_o(drv),
    .supply_good_indicator_o(sgi), .rf_enable_o(rf), .mute_o(mute),
    .remote_state_out_o(st_o), .remote_state_out_oe_o(st_oe),
    .remote_fault_chain_out_o(ch_o), .remote_fault_chain_out_oe_o(ch_oe),
    .remote_aux_line_1_i(a1_l), .remote_aux_line_1_o(a1_o), .remote_aux_line_1_oe_o(a1_oe),
    .remote_aux_line_2_i(a2_oe ? a2_o : 1'b1), .remote_aux_line_2_o(a2_o),
    .remote_aux_line_2_oe_o(a2_oe), .aux_analog_sel_o(asel));

  tmc_far_side far (.clk_i(clk_i), .slow_i(slow), .go_req_i(go), .idle_req_i(idle),
    .loop_closed_i(loop_ok), .aux_pull_low_i(auxlo), .state_o_i(st_o), .state_oe_i(st_oe),
    .chain_o_i(ch_o), .chain_oe_i(ch_oe), .aux1_o_i(a1_o), .aux1_oe_i(a1_oe),
    .go_n_o(go_n), .idle_n_o(idle_n), .loop_open_o(lopen), .state_line_o(st_l),
    .chain_line_o(ch_l), .aux1_line_o(a1_l));

  // Free-running system clock
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask : tick

  task automatic report_and_stop();
    if (bad_count == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk_out(input logic [7:0] exp);
    cmp_count++;
    if (ov !== exp) begin
      bad_count++;
      $display("[FAIL] %0t outputs got %h exp %h", $time, ov, exp);
    end
  endtask : chk_out

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t value got %h exp %h", $time, got, exp);
    end
  endtask : chk_reg

  // One classic cycle; waits for ack (only the watchdog ends a hung wait)
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask : wb

  // Pulse a panel request for one cycle and let the outputs settle
  task automatic panel(input logic sb);
    if (sb) p_sb <= 1'b1;
    else p_op <= 1'b1;
    tick(1);
    p_op <= 1'b0;
    p_sb <= 1'b0;
    tick(3);
  endtask : panel

  // Pins need two sync edges and one output edge before the lamps settle
  task automatic t_reset();
    tick(4);
    chk_out(8'h82);
    wb(1'b0, 8'h10, '0);
    chk_reg(q, 32'h30);
    wb(1'b0, 8'h0c, '0);
    chk_reg(q, 32'h0);
    wb(1'b0, 8'h1c, '0);
    chk_reg(q, 32'h0);
  endtask : t_reset

  task automatic t_mute();
    panel(1'b0);
    chk_out(8'hf8);
    for (int i = 0; i < 3; i++) begin
      if (i == 0) unl <= 1'b1;
      if (i == 1) upa <= 1'b1;
      if (i == 2) loop_ok <= 1'b0;
      tick(5);
      chk_out(8'hf5);
      wb(1'b0, 8'h04, '0);
      chk_reg(q, (i == 0) ? 32'h87 : (i == 1) ? 32'h107 : 32'h47);
      unl <= 1'b0;
      upa <= 1'b0;
      loop_ok <= 1'b1;
      tick(5);
      chk_out(8'hf8);
    end
    panel(1'b1);
    chk_out(8'h82);
    s_ok <= 1'b0;
    tick(4);
    chk_out(8'h02);
    s_ok <= 1'b1;
    tick(4);
  endtask : t_mute

  task automatic t_refuse();
    wb(1'b1, 8'h08, 32'h1f);
    for (int i = 0; i < 3; i++) begin
      if (i == 0) hot <= 1'b1;
      if (i == 1) amp <= 1'b1;
      if (i == 2) unl <= 1'b1;
      tick(4);
      panel(1'b0);
      chk_out(8'h83);
      hot <= 1'b0;
      amp <= 1'b0;
      unl <= 1'b0;
      tick(4);
    end
    idle <= 1'b1;
    tick(10);
    panel(1'b0);
    chk_out(8'h82);
    idle <= 1'b0;
    tick(10);
    wb(1'b0, 8'h08, '0);
    chk_reg(q & 32'h10, 32'h10);
  endtask : t_refuse

  task automatic t_serial_remote();
    wb(1'b1, 8'h00, 32'h1);
    tick(4);
    chk_out(8'hf8);
    wb(1'b1, 8'h00, 32'h3);
    tick(4);
    chk_out(8'h82);
    slow <= 1'b1;
    go <= 1'b1;
    tick(16);
    chk_out(8'hf8);
    go <= 1'b0;
    idle <= 1'b1;
    tick(16);
    chk_out(8'h82);
    idle <= 1'b0;
    slow <= 1'b0;
    tick(10);
  endtask : t_serial_remote

  task automatic t_irq();
    wb(1'b1, 8'h08, 32'h1f);
    wb(1'b1, 8'h0c, 32'h1);
    tick(2);
    chk_reg({31'h0, irq}, 32'h0);
    panel(1'b0);
    chk_reg({31'h0, irq}, 32'h1);
    wb(1'b1, 8'h0c, 32'h0);
    tick(2);
    chk_reg({31'h0, irq}, 32'h0);
    wb(1'b1, 8'h0c, 32'h1);
    tick(2);
    chk_reg({31'h0, irq}, 32'h1);
    wb(1'b1, 8'h08, 32'h1);
    tick(2);
    chk_reg({31'h0, irq}, 32'h0);
    panel(1'b1);
  endtask : t_irq

  task automatic t_aux();
    wb(1'b1, 8'h10, 32'h21);
    tick(2);
    chk_reg({30'h0, a1_l, asel[0]}, 32'h0);
    wb(1'b1, 8'h10, 32'h38);
    auxlo <= 1'b1;
    tick(4);
    chk_reg({29'h0, a1_l, asel}, 32'h2);
    wb(1'b0, 8'h14, '0);
    chk_reg(q & 32'h1, 32'h0);
    // Line 2 as an output pulled low, line 1 back to a plain input
    wb(1'b1, 8'h10, 32'h14);
    tick(2);
    chk_reg({31'h0, a2_oe}, 32'h1);
  endtask : t_aux

  // Watchdog: the sequence needs well under 2000 cycles
  initial begin
    tick(20000);
    bad_count++;
    report_and_stop();
  end

  // Main sequence
  initial begin
    {cyc, stb, we, p_op, p_sb, hot, amp, unl, upa, slow, go, idle, auxlo} = '0;
    {s_ok, loop_ok, rst_i} = 3'h7;
    adr = 8'h00;
    wdat = 32'h0;
    bad_count = 0;
    cmp_count = 0;
    tick(16);
    rst_i <= 1'b0;
    t_reset();
    t_mute();
    t_refuse();
    t_serial_remote();
    t_irq();
    t_aux();
    report_and_stop();
  end
endmodule : test_tmc_mode_ctrl
